//--- design/nibble_cpu_regs.vh
// register map, field positions, opcodes and counts of the instruction execute engine
`ifndef NIBBLE_CPU_REGS_VH
`define NIBBLE_CPU_REGS_VH
// ---------------------------------------------
// register byte offsets
// ---------------------------------------------
`define REG_CMD 8'h00
`define REG_OPND 8'h04
`define REG_STAT 8'h08
`define REG_PC 8'h0c
`define REG_SP 8'h10
`define REG_ACC 8'h14
`define REG_PSW 8'h18
`define REG_BANK 8'h1c
`define REG_CPUCLK 8'h20
`define REG_SYSCLK 8'h24
`define REG_MADDR 8'h28
`define REG_MDATA 8'h2c
// ---------------------------------------------
// operation codes
// ---------------------------------------------
`define OP_NOP 5'h00
`define OP_ROTATE_RIGHT_CARRY_OP 5'h01
`define OP_SKT 5'h02
`define OP_SKF 5'h03
`define OP_TEST_CLEAR_SKIP_OP 5'h04
`define OP_BLOCK_BRANCH_OP 5'h05
`define OP_CALL 5'h06
`define OP_RET 5'h07
`define OP_RETS 5'h08
`define OP_RETI 5'h09
`define OP_PUSHBS 5'h0a
`define OP_POPBS 5'h0b
`define OP_SELRB 5'h0c
`define OP_SELMB 5'h0d
`define OP_HALT 5'h0e
`define OP_STOP 5'h0f
`define OP_TABLE_INDIRECT_OP 5'h10
`define OP_MOVA 5'h11
`define OP_MOVHL 5'h12
`define TABLE_INDIRECT_OP_TBR 2'h0
`define TABLE_INDIRECT_OP_TABLE_CALL_ENTRY 2'h1
`define TABLE_INDIRECT_OP_OTHER 2'h2
`define BM_DIRECT 2'h0
`define BM_LIDX 2'h1
`define BM_HREL 2'h2
// ---------------------------------------------
// field positions and reset values
// ---------------------------------------------
`define PSW_CY 7
`define PSW_MBE 5
`define PSW_RBE 4
`define PCC_HALT 2
`define PCC_STOP 3
`define PC_RST 15'h0000
`define SP_RST 8'h00
`define PSW_RST 8'h00
`define MB_TOP 4'hf
// ---------------------------------------------
// timing counts, machine cycles and pclk per cycle
// ---------------------------------------------
`define CYC_ONE 3'h1
`define CYC_TWO 3'h2
`define CYC_THREE 3'h3
`define CYC_FOUR 3'h4
`define LEN_ONE 2'h1
`define LEN_TWO 2'h2
`define LEN_THREE 2'h3
`define DIV0_DEF 6'h01
`define DIV1_DEF 6'h02
`define DIV2_DEF 6'h04
`define DIV3_DEF 6'h08
`define DIV4_DEF 6'h20
`endif

//--- design/nibble_cpu_instruction_execute.v
// instruction execute engine of a 4-bit core with an apb register port
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/1ns
`default_nettype none
`include "nibble_cpu_regs.vh"
// What this block does
// - skip costs one or two cycles
// - skipped table-indirect op costs one cycle
// - machine cycle is one selectable cpu period
// - bit tests skip on one or zero
// - test-clear skips on one and clears bit
// - l-indexed address from operand and l
// - rotate right through carry in one cycle
// - block branch keeps pc top three bits
// - call pushes five-nibble frame, sp minus six
// - return restores frame; skipping variant skips next
// - interrupt return reloads status word, three cycles
// - push/pop bank selects move sp by two
// - bank select sets register or memory bank
// - halt sets halt bit of clock control
// - stop sets stop bit of clock control
// - table branch clears pc14, three cycles
// - table call pushes frame, four cycles
// - table other op runs in three cycles
// - repeated same-group loads act as no-operation
module nibble_cpu_instruction_execute #(
  parameter [5:0] DIV0 = `DIV0_DEF,
  parameter [5:0] DIV1 = `DIV1_DEF,
  parameter [5:0] DIV2 = `DIV2_DEF,
  parameter [5:0] DIV3 = `DIV3_DEF,
  parameter [5:0] DIV4 = `DIV4_DEF
) (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  output wire cpu_busy,
  output wire halt_mode,
  output wire stop_mode
);
  // ---------------------------------------------
  // state
  // ---------------------------------------------
  reg [4:0] op_q;
  reg [19:0] opnd_q;
  reg [19:0] opnd_reg_q;
  reg [14:0] pc_q;
  reg [7:0] sp_q;
  reg [3:0] a_q;
  reg [3:0] l_q;
  reg [3:0] h_q;
  reg [7:0] psw_q;
  reg [3:0] mbs_q;
  reg [1:0] rbs_q;
  reg [3:0] cpu_clock_control_reg;
  reg system_clock_control_reg;
  reg [7:0] maddr_q;
  reg [3:0] mem_q [0:255];
  reg busy_q;
  reg skip_q;
  reg skipping_q;
  reg last_skipped_q;
  reg [2:0] mc_left_q;
  reg [2:0] last_cyc_q;
  reg [5:0] div_q;
  reg [1:0] grp_q;
  reg [31:0] prdata_q;
  integer i;
  // ---------------------------------------------
  // per-opcode tables
  // ---------------------------------------------
  function [1:0] len_of;
    input [4:0] op;
    begin
      case (op)
        `OP_CALL: len_of = `LEN_THREE;
        `OP_NOP, `OP_ROTATE_RIGHT_CARRY_OP, `OP_RET, `OP_RETS, `OP_RETI, `OP_TABLE_INDIRECT_OP, `OP_MOVA: len_of = `LEN_ONE;
        default: len_of = `LEN_TWO;
      endcase
    end
  endfunction
  function [2:0] cyc_of;
    input [4:0] op;
    input [1:0] kind;
    begin
      case (op)
        `OP_NOP, `OP_ROTATE_RIGHT_CARRY_OP, `OP_MOVA: cyc_of = `CYC_ONE;
        `OP_CALL: cyc_of = `CYC_FOUR;
        `OP_RET, `OP_RETS, `OP_RETI: cyc_of = `CYC_THREE;
        `OP_TABLE_INDIRECT_OP: cyc_of = (kind == `TABLE_INDIRECT_OP_TABLE_CALL_ENTRY) ? `CYC_FOUR : `CYC_THREE;
        default: cyc_of = `CYC_TWO;
      endcase
    end
  endfunction
  function [1:0] grp_of;
    input [4:0] op;
    begin
      case (op)
        `OP_MOVA: grp_of = 2'h1;
        `OP_MOVHL: grp_of = 2'h2;
        default: grp_of = 2'h0;
      endcase
    end
  endfunction
  // ---------------------------------------------
  // effective operation, table entries unwrapped
  // ---------------------------------------------
  wire [1:0] gkind = opnd_q[19:18];
  wire is_table_indirect_op = op_q == `OP_TABLE_INDIRECT_OP;
  wire table_indirect_op_other = is_table_indirect_op && gkind == `TABLE_INDIRECT_OP_OTHER;
  // a nested table op in an entry degrades to a no-op
  wire [4:0] eop = table_indirect_op_other ? opnd_q[17:13] : op_q;
  wire [19:0] eopnd = table_indirect_op_other ? {7'h00, opnd_q[12:0]} : opnd_q;
  wire [14:0] seq_pc = pc_q + {13'h0000, len_of(op_q)};
  wire [1:0] egrp = grp_of(eop);
  wire string_nop = egrp != 2'h0 && egrp == grp_q;
  // ---------------------------------------------
  // bit addressing
  // ---------------------------------------------
  reg [7:0] baddr;
  reg [1:0] bsel;
  always @* begin
    baddr = eopnd[7:0];
    bsel = eopnd[11:10];
    if (eopnd[9:8] == `BM_LIDX) begin
      baddr = {eopnd[7:2], l_q[3:2]};
      bsel = l_q[1:0];
    end else if (eopnd[9:8] == `BM_HREL) begin
      baddr = {h_q, eopnd[3:0]};
    end
  end
  wire [3:0] bnib = mem_q[baddr];
  wire bval = bnib[bsel];
  wire [3:0] bmask = 4'h1 << bsel;
  reg skip_cond;
  always @* begin
    case (eop)
      `OP_SKT: skip_cond = bval;
      `OP_SKF: skip_cond = ~bval;
      `OP_TEST_CLEAR_SKIP_OP: skip_cond = bval;
      `OP_RETS: skip_cond = 1'b1;
      default: skip_cond = 1'b0;
    endcase
  end
  // ---------------------------------------------
  // machine cycle timing
  // ---------------------------------------------
  reg [5:0] div_max;
  always @* begin
    case (cpu_clock_control_reg[1:0])
      2'h0: div_max = DIV0;
      2'h1: div_max = DIV1;
      2'h2: div_max = DIV2;
      default: div_max = DIV3;
    endcase
    if (system_clock_control_reg)
      div_max = DIV4;
  end
  wire mc_tick = busy_q && div_q == div_max - 6'h01;
  wire mc_last = mc_tick && mc_left_q == `CYC_ONE;
  wire halted = cpu_clock_control_reg[`PCC_HALT] | cpu_clock_control_reg[`PCC_STOP];
  wire [1:0] new_len = len_of(pwdata[4:0]);
  // a pending skip charges the skip cost in place of the op's own count
  wire [2:0] skip_cost = (new_len == `LEN_THREE) ? `CYC_TWO : `CYC_ONE;
  wire [2:0] start_cyc = skip_q ? skip_cost : cyc_of(pwdata[4:0], opnd_reg_q[19:18]);
  // ---------------------------------------------
  // apb decode
  // ---------------------------------------------
  wire acc = psel && penable;
  wire setup = psel && !penable;
  reg hit;
  reg [31:0] rd_mux;
  always @* begin
    hit = 1'b1;
    rd_mux = 32'h0000_0000;
    if (paddr == `REG_CMD)
      rd_mux = {27'h000_0000, op_q};
    else if (paddr == `REG_OPND)
      rd_mux = {12'h000, opnd_reg_q};
    else if (paddr == `REG_STAT)
      rd_mux = {24'h00_0000, last_skipped_q, last_cyc_q, stop_mode, halt_mode, skip_q, busy_q};
    else if (paddr == `REG_PC)
      rd_mux = {17'h0_0000, pc_q};
    else if (paddr == `REG_SP)
      rd_mux = {24'h00_0000, sp_q};
    else if (paddr == `REG_ACC)
      rd_mux = {20'h0_0000, h_q, l_q, a_q};
    else if (paddr == `REG_PSW)
      rd_mux = {24'h00_0000, psw_q};
    else if (paddr == `REG_BANK)
      rd_mux = {26'h000_0000, rbs_q, mbs_q};
    else if (paddr == `REG_CPUCLK)
      rd_mux = {28'h000_0000, cpu_clock_control_reg};
    else if (paddr == `REG_SYSCLK)
      rd_mux = {31'h0000_0000, system_clock_control_reg};
    else if (paddr == `REG_MADDR)
      rd_mux = {24'h00_0000, maddr_q};
    else if (paddr == `REG_MDATA)
      rd_mux = {28'h000_0000, mem_q[maddr_q]};
    else
      hit = 1'b0;
  end
  // writes race the engine, so all of them are refused with pslverr while it is busy
  wire cmd_bad = paddr == `REG_CMD && halted;
  wire wr_bad = pwrite && (busy_q || cmd_bad || paddr == `REG_STAT);
  assign pslverr = acc && (!hit || wr_bad);
  assign pready = 1'b1;
  wire wr_ok = acc && pwrite && hit && !wr_bad && ce;
  wire start = wr_ok && paddr == `REG_CMD;
  // ---------------------------------------------
  // engine and register file
  // ---------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_q <= `OP_NOP;
      opnd_q <= 20'h0_0000;
      opnd_reg_q <= 20'h0_0000;
      pc_q <= `PC_RST;
      sp_q <= `SP_RST;
      a_q <= 4'h0;
      l_q <= 4'h0;
      h_q <= 4'h0;
      psw_q <= `PSW_RST;
      mbs_q <= 4'h0;
      rbs_q <= 2'h0;
      cpu_clock_control_reg <= 4'h0;
      system_clock_control_reg <= 1'b0;
      maddr_q <= 8'h00;
      busy_q <= 1'b0;
      skip_q <= 1'b0;
      skipping_q <= 1'b0;
      last_skipped_q <= 1'b0;
      mc_left_q <= 3'h0;
      last_cyc_q <= 3'h0;
      div_q <= 6'h00;
      grp_q <= 2'h0;
      prdata_q <= 32'h0000_0000;
      for (i = 0; i < 256; i = i + 1)
        mem_q[i] <= 4'h0;
    end else if (ce) begin
      if (setup)
        prdata_q <= rd_mux;
      if (start) begin
        op_q <= pwdata[4:0];
        opnd_q <= opnd_reg_q;
        skipping_q <= skip_q;
        mc_left_q <= start_cyc;
        last_cyc_q <= start_cyc;
        div_q <= 6'h00;
        busy_q <= 1'b1;
      end else if (wr_ok) begin
        if (paddr == `REG_OPND)
          opnd_reg_q <= pwdata[19:0];
        else if (paddr == `REG_PC)
          pc_q <= pwdata[14:0];
        else if (paddr == `REG_SP)
          sp_q <= pwdata[7:0];
        else if (paddr == `REG_ACC) begin
          a_q <= pwdata[3:0];
          l_q <= pwdata[7:4];
          h_q <= pwdata[11:8];
        end else if (paddr == `REG_PSW)
          psw_q <= pwdata[7:0];
        else if (paddr == `REG_BANK) begin
          mbs_q <= pwdata[3:0];
          rbs_q <= pwdata[5:4];
        end else if (paddr == `REG_CPUCLK)
          cpu_clock_control_reg <= pwdata[3:0];
        else if (paddr == `REG_SYSCLK)
          system_clock_control_reg <= pwdata[0];
        else if (paddr == `REG_MADDR)
          maddr_q <= pwdata[7:0];
        else if (paddr == `REG_MDATA)
          mem_q[maddr_q] <= pwdata[3:0];
      end
      if (mc_tick) begin
        div_q <= 6'h00;
        mc_left_q <= mc_left_q - 3'h1;
      end else if (busy_q)
        div_q <= div_q + 6'h01;
      if (mc_last) begin
        busy_q <= 1'b0;
        last_skipped_q <= skipping_q;
        pc_q <= seq_pc;
        if (skipping_q) begin
          skip_q <= 1'b0;
          grp_q <= 2'h0;
        end else if (string_nop) begin
          skip_q <= 1'b0;
        end else begin
          skip_q <= skip_cond;
          grp_q <= egrp;
          case (eop)
            `OP_ROTATE_RIGHT_CARRY_OP: begin
              psw_q[`PSW_CY] <= a_q[0];
              a_q <= {psw_q[`PSW_CY], a_q[3:1]};
            end
            `OP_TEST_CLEAR_SKIP_OP: mem_q[baddr] <= bnib & ~bmask;
            `OP_BLOCK_BRANCH_OP: pc_q <= {pc_q[14:12], eopnd[11:0]};
            `OP_CALL, `OP_TABLE_INDIRECT_OP: begin
              if (eop == `OP_CALL || gkind == `TABLE_INDIRECT_OP_TABLE_CALL_ENTRY) begin
                mem_q[sp_q - 8'h05] <= {1'b0, seq_pc[14:12]};
                mem_q[sp_q - 8'h06] <= seq_pc[11:8];
                mem_q[sp_q - 8'h03] <= seq_pc[7:4];
                mem_q[sp_q - 8'h04] <= seq_pc[3:0];
                mem_q[sp_q - 8'h02] <= {2'h0, psw_q[`PSW_MBE], psw_q[`PSW_RBE]};
                sp_q <= sp_q - 8'h06;
              end
              if (eop == `OP_CALL || gkind == `TABLE_INDIRECT_OP_TABLE_CALL_ENTRY || gkind == `TABLE_INDIRECT_OP_TBR)
                pc_q <= {1'b0, eopnd[13:0]};
            end
            `OP_RET, `OP_RETS, `OP_RETI: begin
              pc_q <= {mem_q[sp_q + 8'h01][2:0], mem_q[sp_q], mem_q[sp_q + 8'h03], mem_q[sp_q + 8'h02]};
              sp_q <= sp_q + 8'h06;
              if (eop == `OP_RETI)
                psw_q <= {mem_q[sp_q + 8'h04], mem_q[sp_q + 8'h05]};
              else begin
                psw_q[`PSW_MBE] <= mem_q[sp_q + 8'h04][1];
                psw_q[`PSW_RBE] <= mem_q[sp_q + 8'h04][0];
              end
            end
            `OP_PUSHBS: begin
              mem_q[sp_q - 8'h01] <= mbs_q;
              mem_q[sp_q - 8'h02] <= {2'h0, rbs_q};
              sp_q <= sp_q - 8'h02;
            end
            `OP_POPBS: begin
              mbs_q <= mem_q[sp_q + 8'h01];
              rbs_q <= mem_q[sp_q][1:0];
              sp_q <= sp_q + 8'h02;
            end
            `OP_SELRB: rbs_q <= eopnd[1:0];
            `OP_SELMB: begin
              // unlisted banks are ignored rather than aliased
              if (eopnd[3:2] == 2'h0 || eopnd[3:0] == `MB_TOP)
                mbs_q <= eopnd[3:0];
            end
            `OP_HALT: cpu_clock_control_reg[`PCC_HALT] <= 1'b1;
            `OP_STOP: cpu_clock_control_reg[`PCC_STOP] <= 1'b1;
            `OP_MOVA: a_q <= eopnd[3:0];
            `OP_MOVHL: begin
              h_q <= eopnd[7:4];
              l_q <= eopnd[3:0];
            end
            default: begin
            end
          endcase
        end
      end
    end
  end
  // ---------------------------------------------
  // outputs
  // ---------------------------------------------
  assign prdata = prdata_q;
  assign cpu_busy = busy_q;
  assign halt_mode = cpu_clock_control_reg[`PCC_HALT];
  assign stop_mode = cpu_clock_control_reg[`PCC_STOP];
endmodule // nibble_cpu_instruction_execute
`default_nettype wire

//--- tb/exec_checker.sv
// port checker for the instruction execute engine
`timescale 1ns/1ns
`default_nettype none
module exec_checker (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire cpu_busy,
  input wire halt_mode,
  input wire stop_mode
);
  // ----------------------------------------
  // shared terms
  // ----------------------------------------
  localparam int MAX_WAIT = 160;
  wire acc_wr = psel && penable && pwrite;
  wire clk_wr = acc_wr && paddr == 8'h20;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence cmd_take;
    acc_wr && paddr == 8'h00 && !pslverr && ce;
  endsequence
  // longest op is four cycles of the slowest period
  sequence busy_run;
    cpu_busy ##[1:MAX_WAIT] !cpu_busy;
  endsequence
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_cmd_busy_run: assert property (cmd_take |=> busy_run)
    else $error("accepted command did not run a bounded busy span");
  a_busy_wr_refuse: assert property (acc_wr && cpu_busy |-> pslverr)
    else $error("write accepted while busy");
  a_stat_ro: assert property (acc_wr && paddr == 8'h08 |-> pslverr)
    else $error("status write accepted");
  a_halt_refuse: assert property (acc_wr && paddr == 8'h00 && halt_mode |-> pslverr)
    else $error("command accepted in halt");
  a_stop_refuse: assert property (acc_wr && paddr == 8'h00 && stop_mode |-> pslverr)
    else $error("command accepted in stop");
  a_halt_cause: assert property ($rose(halt_mode) |-> $past(cpu_busy) || $past(clk_wr))
    else $error("halt set without an op or a clock write");
  a_stop_cause: assert property ($rose(stop_mode) |-> $past(cpu_busy) || $past(clk_wr))
    else $error("stop set without an op or a clock write");
  a_halt_hold: assert property (halt_mode && !clk_wr |=> halt_mode)
    else $error("halt dropped by itself");
  a_stop_hold: assert property (stop_mode && !clk_wr |=> stop_mode)
    else $error("stop dropped by itself");
endmodule // exec_checker
bind nibble_cpu_instruction_execute exec_checker chk_u (.pclk(pclk), .presetn(presetn), .ce(ce),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .cpu_busy(cpu_busy), .halt_mode(halt_mode), .stop_mode(stop_mode));
`default_nettype wire

//--- tb/ref_mem.sv
// reference image of the data memory layout
`timescale 1ns/1ns
`default_nettype none
module ref_mem;
  // ----------------------------------------
  // frame and address helpers
  // ----------------------------------------
  // no port ops reach this block, bank legality stays with software
  function automatic logic [3:0] frame_nib(input logic [14:0] pc, input logic [1:0] en, input int k);
    case (k)
      0: frame_nib = pc[11:8];
      1: frame_nib = {1'b0, pc[14:12]};
      2: frame_nib = pc[3:0];
      3: frame_nib = pc[7:4];
      default: frame_nib = {2'b00, en};
    endcase
  endfunction
  function automatic logic [7:0] lidx(input logic [7:0] opnd, input logic [3:0] l);
    lidx = {opnd[7:2], l[3:2]};
  endfunction
endmodule // ref_mem
`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench of the instruction execute engine
`timescale 1ns/1ns
`default_nettype none
`include "nibble_cpu_regs.vh"
module tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  wire [31:0] prdata;
  wire pready, pslverr, cpu_busy, halt_mode, stop_mode;
  int fails = 0;
  int check_count = 0;
  int n;
  logic [31:0] rd;
  int divs [5] = '{1, 2, 4, 8, 32};
  logic [3:0] mb [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'hf, 4'h5};
  always #50 pclk = ~pclk;
  nibble_cpu_instruction_execute dut_u (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cpu_busy(cpu_busy), .halt_mode(halt_mode), .stop_mode(stop_mode));
  ref_mem ref_u ();
  // ----------------------------------------
  // bus and compare tasks
  // ----------------------------------------
  task eq(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    if (w) eq({31'h0, pslverr}, {31'h0, e});
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0);
  endtask
  task ck(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000, 1'b0);
    eq(rd, e);
  endtask
  // busy span is counted at falling edges, away from the launch edge
  task ex(input logic [4:0] op, input logic [19:0] opnd);
    wr(`REG_OPND, {12'h000, opnd});
    wr(`REG_CMD, {27'h0, op});
    @(negedge pclk);
    n = 0;
    while (cpu_busy === 1'b1) begin
      n++;
      @(negedge pclk);
    end
  endtask
  task complete_run;
    $display("fails=%0d checks=%0d", fails, check_count);
    if (fails == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #(20000 * 100);
    fails++;
    complete_run;
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    ck(`REG_STAT, 8'h00);
    wr(`REG_ACC, 8'h06); wr(`REG_PSW, 8'h80); ex(`OP_ROTATE_RIGHT_CARRY_OP, 20'h0_0000);
    ck(`REG_ACC, 8'h0b); ck(`REG_PSW, 8'h00); ck(`REG_STAT, 8'h10);
    wr(`REG_ACC, 8'hb0); wr(`REG_MADDR, ref_u.lidx(8'h34, 4'hb)); wr(`REG_MDATA, 8'h08);
    ex(`OP_SKT, 20'h0_0134); ck(`REG_STAT, 8'h22);
    ex(`OP_MOVA, 20'h0_0005); ck(`REG_ACC, 8'hb0); ck(`REG_STAT, 8'h90);
    ex(`OP_SKF, 20'h0_0134); ck(`REG_STAT, 8'h20);
    ex(`OP_TEST_CLEAR_SKIP_OP, 20'h0_0c36); ck(`REG_STAT, 8'h22); ck(`REG_MDATA, 8'h00);
    wr(`REG_PC, 16'h0100); wr(`REG_SP, 8'h40); ex(`OP_CALL, 20'h0_0055);
    ck(`REG_STAT, 8'ha0); ck(`REG_PC, 16'h0103); ck(`REG_SP, 8'h40);
    ex(`OP_SKF, 20'h0_0134); ex(`OP_TABLE_INDIRECT_OP, 20'h4_0000); ck(`REG_STAT, 8'h90);
    wr(`REG_PC, 16'h0567); wr(`REG_PSW, 8'h30); ex(`OP_CALL, 20'h0_1234);
    ck(`REG_STAT, 8'h40); ck(`REG_PC, 16'h1234); ck(`REG_SP, 8'h3a);
    for (int k = 0; k < 5; k++) begin
      wr(`REG_MADDR, 8'h3a + k[7:0]);
      ck(`REG_MDATA, {28'h0, ref_u.frame_nib(15'h056a, 2'b11, k)});
    end
    wr(`REG_PSW, 8'h00); ex(`OP_RET, 20'h0_0000);
    ck(`REG_PC, 16'h056a); ck(`REG_SP, 8'h40); ck(`REG_PSW, 8'h30); ck(`REG_STAT, 8'h30);
    wr(`REG_SP, 8'h3a); ex(`OP_RETS, 20'h0_0000); ck(`REG_STAT, 8'h32);
    ex(`OP_NOP, 20'h0_0000);
    wr(`REG_MADDR, 8'h3f); wr(`REG_MDATA, 8'h0c); wr(`REG_SP, 8'h3a); ex(`OP_RETI, 20'h0_0000);
    ck(`REG_PC, 16'h056a); ck(`REG_PSW, 8'h3c); ck(`REG_SP, 8'h40); ck(`REG_STAT, 8'h30);
    wr(`REG_BANK, 8'h23); wr(`REG_SP, 8'h20); ex(`OP_PUSHBS, 20'h0_0000); ck(`REG_SP, 8'h1e);
    wr(`REG_MADDR, 8'h1f); ck(`REG_MDATA, 8'h03); wr(`REG_MADDR, 8'h1e); ck(`REG_MDATA, 8'h02);
    wr(`REG_BANK, 8'h00); ex(`OP_POPBS, 20'h0_0000); ck(`REG_BANK, 8'h23); ck(`REG_SP, 8'h20);
    for (int i = 0; i < 4; i++) begin
      ex(`OP_SELRB, i[19:0]); ck(`REG_BANK, {i[3:0], 4'h3});
    end
    ck(`REG_STAT, 8'h20);
    for (int i = 0; i < 6; i++) begin
      ex(`OP_SELMB, {16'h0000, mb[i]}); ck(`REG_BANK, {4'h3, (mb[i] == 4'h5) ? 4'hf : mb[i]});
    end
    wr(`REG_PC, 16'h5abc); ex(`OP_BLOCK_BRANCH_OP, 20'h0_0123); ck(`REG_PC, 16'h5123);
    wr(`REG_PC, 16'h4000); ex(`OP_TABLE_INDIRECT_OP, 20'h0_2345); ck(`REG_PC, 16'h2345); ck(`REG_STAT, 8'h30);
    wr(`REG_SP, 8'h40); ex(`OP_TABLE_INDIRECT_OP, 20'h4_0100);
    ck(`REG_PC, 16'h0100); ck(`REG_SP, 8'h3a); ck(`REG_STAT, 8'h40);
    wr(`REG_ACC, 8'h06); wr(`REG_PSW, 8'h00); ex(`OP_TABLE_INDIRECT_OP, 20'h8_2000);
    ck(`REG_ACC, 8'h03); ck(`REG_STAT, 8'h30);
    ex(`OP_MOVA, 20'h0_0005); ex(`OP_MOVA, 20'h0_0007); ck(`REG_ACC, 8'h05);
    ex(`OP_MOVHL, 20'h0_003c); ck(`REG_ACC, 16'h03c5);
    for (int i = 0; i < 5; i++) begin
      wr(`REG_CPUCLK, (i < 4) ? i : 0); wr(`REG_SYSCLK, (i == 4) ? 1 : 0);
      ex(`OP_NOP, 20'h0_0000); eq(n, divs[i]);
    end
    wr(`REG_CMD, {27'h0, `OP_NOP}); apb(1'b1, `REG_PC, 32'h0000_0000, 1'b1);
    wait (cpu_busy === 1'b0);
    ex(`OP_NOP, 20'h0_0000); wr(`REG_SYSCLK, 8'h00);
    ex(`OP_HALT, 20'h0_0000); ck(`REG_STAT, 8'h24);
    apb(1'b1, `REG_CMD, {27'h0, `OP_NOP}, 1'b1); wr(`REG_CPUCLK, 8'h00);
    ex(`OP_STOP, 20'h0_0000); ck(`REG_STAT, 8'h28);
    apb(1'b1, `REG_CMD, {27'h0, `OP_NOP}, 1'b1); wr(`REG_CPUCLK, 8'h00);
    apb(1'b1, `REG_STAT, 32'h0000_0000, 1'b1); apb(1'b1, 8'h30, 32'h0000_0000, 1'b1);
    complete_run;
  end
endmodule // tb_top
`default_nettype wire
